/* sim/subroutine_return_logic_chk.sv */
// Checker for the subroutine return logic ports.
`timescale 1ns/100ps
module ret_chk #(parameter int PC_WIDTH = 21) (
  input wire logic sys_clk_in, rst_in, opcode_valid_in, pc_load_out, stack_pop_out, flush_out,
  input wire logic [15:0] opcode_in,
  input wire logic [PC_WIDTH-1:0] stack_top_value_in, pc_out,
  input wire logic [7:0] shadow_working_reg_in, shadow_flags_reg_in, file_data_in,
  input wire logic [7:0] working_out, flags_out, pc_high_latch_in, pc_high_latch_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire tk = opcode_valid_in && !flush_out;
  wire rt = tk && opcode_in[15:1] == 15'h0008;
  wire lw = tk && opcode_in[15:8] == 8'h0c;
  wire rl = tk && opcode_in[15:9] == 7'h1a;
  a_return_pops_pc: assert property (rt |=> pc_load_out && stack_pop_out && flush_out &&
    pc_out == $past(stack_top_value_in) ##1 !flush_out) else $error("return pop wrong");
  a_fast_restores: assert property (tk && opcode_in == 16'h0011 |=>
    working_out == $past(shadow_working_reg_in) && flags_out == $past(shadow_flags_reg_in))
    else $error("fast restore wrong");
  a_slow_keeps: assert property (tk && opcode_in == 16'h0010 |=>
    $stable(working_out) && $stable(flags_out)) else $error("slow return changed regs");
  a_latch_kept: assert property (rt || lw |=>
    pc_high_latch_out == $past(pc_high_latch_in)) else $error("latch altered");
  a_flush_cause: assert property ($rose(flush_out) |-> $past(rt || lw))
    else $error("flush without return");
  a_literal_loads: assert property (lw |=>
    working_out == $past(opcode_in[7:0]) && stack_pop_out) else $error("literal return wrong");
  a_rotate_carry: assert property (rl |=> working_out ==
    {$past(file_data_in[6:0]), $past(flags_out[0])} && flags_out[0] == $past(file_data_in[7]))
    else $error("rotate wrong");
  c_return: cover property (rt);
  c_literal: cover property (lw);
  c_rotate: cover property (rl);
endmodule : ret_chk
bind subroutine_return_logic ret_chk #(.PC_WIDTH(PC_WIDTH)) chk (.*);

/* sim/test_subroutine_return_logic.sv */
// Self-checking bench for the subroutine return logic.
`timescale 1ns/100ps
module test_subroutine_return_logic;
  import return_logic_pkg::*;
  logic sys_clk_in = 0, rst_in = 1, opcode_valid_in = 0, pc_load_out, flush_out;
  logic stack_pop_out, file_write_out;
  logic [15:0] opcode_in = 0;
  logic [20:0] top = 0, pc_out;
  logic [7:0] sw = 0, sf = 0, sb = 0, fd = 0, up = 0, hi = 0, w, f, b, rot, working_out;
  logic [7:0] flags_out, bank_select_reg_out, file_write_data_out;
  logic [7:0] pc_upper_latch_out, pc_high_latch_out;
  logic [63:0] q[$];
  logic [7:0] qf[$];
  int fails = 0, comparisons = 0, cyc = 0, seed = 32'h7e05, k;
  subroutine_return_logic dut (.sys_clk_in, .rst_in, .opcode_in, .opcode_valid_in,
    .stack_top_value_in(top), .shadow_working_reg_in(sw), .shadow_flags_reg_in(sf),
    .shadow_bank_select_in(sb), .file_data_in(fd), .pc_upper_latch_in(up),
    .pc_high_latch_in(hi), .pc_out, .pc_load_out, .stack_pop_out, .working_out,
    .flags_out, .bank_select_reg_out, .file_write_data_out, .file_write_out,
    .pc_upper_latch_out, .pc_high_latch_out, .flush_out);
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (++cyc == 2000) begin
    fails++;
    stop_test();
  end
  task chk_ret(input logic [63:0] e);
    logic [63:0] s;
    s = {stack_pop_out, flush_out, pc_load_out, pc_out, working_out, flags_out,
      bank_select_reg_out, pc_upper_latch_out, pc_high_latch_out};
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("ERROR return_state expected %h seen %h", e, s);
    end
  endtask : chk_ret
  task chk_file(input logic [7:0] e);
    comparisons++;
    if (file_write_data_out !== e) begin
      fails++;
      $display("ERROR file_write_data expected %h seen %h", e, file_write_data_out);
    end
  endtask : chk_file
  task chk_reset;
    logic [99:0] s;
    s = {stack_pop_out, flush_out, pc_load_out, file_write_out, pc_out, working_out,
      flags_out, bank_select_reg_out, file_write_data_out, pc_upper_latch_out,
      pc_high_latch_out};
    comparisons++;
    if (s !== '0) begin
      fails++;
      $display("ERROR reset_outputs expected 0 seen %h", s);
    end
  endtask : chk_reset
  task stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  always @(posedge sys_clk_in) begin
    #1;
    if (pc_load_out === 1'b1) chk_ret(q.pop_front());
    if (file_write_out === 1'b1) chk_file(qf.pop_front());
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      opcode_valid_in = 0;
      rst_in = 1;
      repeat (p == 0 ? 20 : 2) @(negedge sys_clk_in);
      chk_reset();
      rst_in = 0;
      w = 0;
      f = 0;
      b = 0;
      for (int i = 0; i < 200; i++) begin
        k = $unsigned($random(seed)) % 6;
        {top, sw, sf, sb, fd} = 53'({$random(seed), $random(seed)});
        {up, hi} = 16'($random(seed));
        opcode_in = k < 2 ? {15'h0008, k[0]} : k == 2 ? {8'h0c, fd}
          : k == 5 ? 16'h0011 : {6'h0d, k == 4, 1'b0, sb};
        opcode_valid_in = (k != 5);
        rot = {fd[6:0], f[0]};
        if (k < 3) q.push_back({3'b111, top, k == 1 ? sw : k == 2 ? fd : w,
          k == 1 ? sf : f, k == 1 ? sb : b, up, hi});
        if (k == 1) {w, f, b} = {sw, sf, sb};
        if (k == 2) w = fd;
        if (k == 3) w = rot;
        if (k == 4) qf.push_back(rot);
        if (k == 3 || k == 4) begin
          f[0] = fd[7];
          f[4] = rot[7];
          f[2] = (rot == 8'h00);
        end
        @(negedge sys_clk_in);
        if (k < 3) begin
          opcode_in = 16'h0011;
          @(negedge sys_clk_in);
        end
      end
    end
    opcode_valid_in = 0;
    repeat (3) @(negedge sys_clk_in);
    if (q.size() != 0 || qf.size() != 0) fails++;
    stop_test();
  end
endmodule : test_subroutine_return_logic

/* verilog/return_logic_pkg.sv */
// Package with opcode patterns, field positions, phase and reset constants.
package return_logic_pkg;
  localparam logic [11:0] RETURN_PATTERN = 12'h001;
  localparam logic [2:0] RETURN_FILL = 3'h0;
  localparam logic [7:0] LITERAL_RETURN_PATTERN = 8'h0c;
  localparam logic [5:0] ROTATE_PATTERN = 6'h0d;
  localparam int FAST_BIT = 0;
  localparam int DEST_BIT = 9;
  localparam int RETURN_CYCLES = 2;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;
  typedef enum logic [1:0] {exec_type_fetch, exec_type_second} dummy_unused_type;
  typedef enum {st_execute, st_flush} exec_state_type;
endpackage : return_logic_pkg

/* verilog/subroutine_return_logic.sv */
// Return, return-with-literal and rotate-left-through-carry execution for the core.
//
// Function
// RULE_01 - Return pops stack into program counter over two cycles, second cycle idle.
// RULE_02 - Fast bit set restores working, status and bank select from shadows.
// RULE_03 - Fast bit clear leaves working, status and bank select untouched.
// RULE_04 - Return keeps upper and high latches; flags change only on shadow restore.
// RULE_05 - Return opcode is leading pattern 0000 0000 0001 with fast bit at bit 0.
// RULE_06 - Return-with-literal loads working with literal and pops stack, two cycles.
// RULE_07 - Rotate left through carry writes working or file, updates carry, negative, zero.
`timescale 1ns/100ps
module subroutine_return_logic
  import return_logic_pkg::*;
#(
  parameter int PC_WIDTH = 21
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] opcode_in,
  input wire logic opcode_valid_in,
  input wire logic [PC_WIDTH-1:0] stack_top_value_in,
  input wire logic [7:0] shadow_working_reg_in,
  input wire logic [7:0] shadow_flags_reg_in,
  input wire logic [7:0] shadow_bank_select_in,
  input wire logic [7:0] file_data_in,
  input wire logic [7:0] pc_upper_latch_in,
  input wire logic [7:0] pc_high_latch_in,
  output logic [PC_WIDTH-1:0] pc_out,
  output logic pc_load_out,
  output logic stack_pop_out,
  output logic [7:0] working_out,
  output logic [7:0] flags_out,
  output logic [7:0] bank_select_reg_out,
  output logic [7:0] file_write_data_out,
  output logic file_write_out,
  output logic [7:0] pc_upper_latch_out,
  output logic [7:0] pc_high_latch_out,
  output logic flush_out
);

  // The program counter width must fit the popped stack value and stay within a word.
  if (PC_WIDTH < 1 || PC_WIDTH > 32) begin : g_width_check
    $error("PC_WIDTH out of range");
  end

  exec_state_type state;
  exec_state_type next_state;

  // Instruction decode; nothing is taken in the idle second cycle of a return.
  wire logic in_execute = (state == st_execute);
  wire logic take = opcode_valid_in && in_execute;
  wire logic return_head = (opcode_in[15:4] == RETURN_PATTERN); // RULE_05
  wire logic return_fill = (opcode_in[3:1] == RETURN_FILL); // RULE_05
  wire logic is_return = take && return_head && return_fill; // RULE_05
  wire logic fast = opcode_in[FAST_BIT];
  wire logic literal_head = (opcode_in[15:8] == LITERAL_RETURN_PATTERN);
  wire logic is_literal_return = take && literal_head; // RULE_06
  wire logic rotate_head = (opcode_in[15:10] == ROTATE_PATTERN);
  wire logic is_rotate = take && rotate_head; // RULE_07
  wire logic is_pop = is_return || is_literal_return; // RULE_01
  wire logic to_file = opcode_in[DEST_BIT];
  wire logic restore = is_return && fast; // RULE_02

  // Rotate left through carry, one bit at a time.
  logic [7:0] rot_value;
  for (genvar i = 0; i < 8; i++) begin : g_rotate
    if (i == 0) begin : g_carry_in
      assign rot_value[i] = flags_out[FLAG_C]; // RULE_07
    end else begin : g_shift
      assign rot_value[i] = file_data_in[i-1]; // RULE_07
    end
  end

  wire logic rot_zero = (rot_value == BYTE_RESET);

  logic [7:0] rot_flags;
  always_comb begin
    rot_flags = flags_out;
    rot_flags[FLAG_C] = file_data_in[7]; // RULE_07
    rot_flags[FLAG_N] = rot_value[7]; // RULE_07
    rot_flags[FLAG_Z] = rot_zero; // RULE_07
  end

  // Next values of the core registers.
  wire logic rotate_to_working = is_rotate && !to_file;
  wire logic rotate_to_file = is_rotate && to_file;
  wire logic [7:0] next_working = restore ? shadow_working_reg_in // RULE_02
    : is_literal_return ? opcode_in[7:0] // RULE_06
    : rotate_to_working ? rot_value : working_out; // RULE_03
  wire logic [7:0] next_flags = restore ? shadow_flags_reg_in // RULE_02
    : is_rotate ? rot_flags : flags_out; // RULE_04
  wire logic [7:0] next_bank = restore ? shadow_bank_select_in // RULE_02
    : bank_select_reg_out; // RULE_03
  wire logic [PC_WIDTH-1:0] next_pc = is_pop ? stack_top_value_in : pc_out; // RULE_01
  wire logic [7:0] next_file_data = rotate_to_file ? rot_value : file_write_data_out;

  always_comb begin
    next_state = state;
    unique case (state)
      st_execute: begin
        if (is_pop) begin
          next_state = st_flush; // RULE_01
        end
      end
      st_flush: begin
        next_state = st_execute;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= st_execute;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_out <= '0;
    end else begin
      pc_out <= next_pc; // RULE_01
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_load_out <= 1'b0;
    end else begin
      pc_load_out <= is_pop; // RULE_01
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stack_pop_out <= 1'b0;
    end else begin
      stack_pop_out <= is_pop; // RULE_01
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flush_out <= 1'b0;
    end else begin
      flush_out <= is_pop; // RULE_01
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      working_out <= BYTE_RESET;
    end else begin
      working_out <= next_working;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= BYTE_RESET;
    end else begin
      flags_out <= next_flags;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bank_select_reg_out <= BYTE_RESET;
    end else begin
      bank_select_reg_out <= next_bank;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      file_write_data_out <= BYTE_RESET;
    end else begin
      file_write_data_out <= next_file_data; // RULE_07
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      file_write_out <= 1'b0;
    end else begin
      file_write_out <= rotate_to_file; // RULE_07
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_upper_latch_out <= BYTE_RESET;
    end else begin
      pc_upper_latch_out <= pc_upper_latch_in; // RULE_04
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_high_latch_out <= BYTE_RESET;
    end else begin
      pc_high_latch_out <= pc_high_latch_in; // RULE_04
    end
  end

endmodule : subroutine_return_logic
